// ---- cspsc_defs.vh ----
// Constants for the clock switch and power save controller
`ifndef CSPSC_DEFS_VH
`define CSPSC_DEFS_VH
`define CSPSC_SEL_FRC 3'h0
`define CSPSC_SEL_FAST_RC_MULTIPLIED 3'h1
`define CSPSC_SEL_PRI 3'h2
`define CSPSC_SEL_PRIPLL 3'h3
`define CSPSC_SEL_SEC 3'h4
`define CSPSC_SEL_LOW_POWER_RC_OSC 3'h5
`define CSPSC_SEL_FRC16 3'h6
`define CSPSC_SEL_FRCN 3'h7
`define CSPSC_SETTLE_CYCLES 4'hA
`define CSPSC_ST_IDLE 3'h0
`define CSPSC_ST_START 3'h1
`define CSPSC_ST_COUNT 3'h2
`define CSPSC_ST_DONE 3'h3
`define CSPSC_PS_RUN 2'h0
`define CSPSC_PS_SLEEP 2'h1
`define CSPSC_PS_IDLE 2'h2
`define CSPSC_OSC_FRC 0
`define CSPSC_OSC_PRI 1
`define CSPSC_OSC_SEC 2
`define CSPSC_OSC_LOW_POWER_RC_OSC 3
`define CSPSC_OSC_PLL 4
`endif

// ---- cspsc_edge_count.v ----
// Counter of rising edges of the incoming new source clock
`timescale 1ns/100ps
`include "cspsc_defs.vh"
module cspsc_edge_count #(
    parameter CW = 4
) (
    clk,
    rst,
    clr,
    src_clk_lvl,
    target,
    done
);
    input wire clk;
    input wire rst;
    input wire clr;
    input wire src_clk_lvl;
    input wire [CW-1:0] target;
    output reg done;

    reg sync1_r;
    reg sync2_r;
    reg sync3_r;
    reg [CW-1:0] cnt_r;

    // The source clock is sampled as a level; first flop feeds only the second
    always @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            cnt_r <= {CW{1'b0}};
            done <= 1'b0;
        end else begin
            sync1_r <= src_clk_lvl;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (clr) begin
                cnt_r <= {CW{1'b0}};
                done <= 1'b0;
            end else if (sync2_r && !sync3_r && !done) begin
                cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
                if (cnt_r + {{(CW-1){1'b0}}, 1'b1} == target) begin
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- cspsc_top.v ----
// Clock switching, fail-safe fallback and sleep/idle control
`timescale 1ns/100ps
`include "cspsc_defs.vh"
module cspsc_top (
    clk,
    rst,
    switch_enable_config_n,
    reset_clock_source_config,
    wdt_enabled,
    sel_wr,
    sel_wr_data,
    req_wr,
    req_wr_data,
    secondary_osc_enable,
    clock_fail_flag_clr,
    osc_running,
    crystal_startup_done,
    pll_locked,
    new_clk_lvl,
    osc_fail,
    ps_exec,
    ps_sleep_sel,
    irq_wake,
    wdt_timeout,
    requested_clock_select,
    active_clock_select,
    switch_request_flag,
    clock_fail_flag,
    lock_status,
    osc_enable,
    clock_fail_trap,
    wdt_clear,
    sys_clk_gate_en,
    cpu_clk_en,
    periph_clk_en,
    in_sleep,
    in_idle,
    wake_pulse
);
    input wire clk;
    input wire rst;
    input wire switch_enable_config_n;
    input wire [2:0] reset_clock_source_config;
    input wire wdt_enabled;
    input wire sel_wr;
    input wire [2:0] sel_wr_data;
    input wire req_wr;
    input wire req_wr_data;
    input wire secondary_osc_enable;
    input wire clock_fail_flag_clr;
    input wire [4:0] osc_running;
    input wire crystal_startup_done;
    input wire pll_locked;
    input wire new_clk_lvl;
    input wire osc_fail;
    input wire ps_exec;
    input wire ps_sleep_sel;
    input wire irq_wake;
    input wire wdt_timeout;
    output reg [2:0] requested_clock_select;
    output reg [2:0] active_clock_select;
    output reg switch_request_flag;
    output reg clock_fail_flag;
    output reg lock_status;
    output reg [4:0] osc_enable;
    output reg clock_fail_trap;
    output reg wdt_clear;
    output reg sys_clk_gate_en;
    output reg cpu_clk_en;
    output reg periph_clk_en;
    output reg in_sleep;
    output reg in_idle;
    output reg wake_pulse;

    reg [2:0] sw_state_r;
    reg [1:0] ps_state_r;
    reg wake_pend_r;
    reg cfg_taken_r;
    reg cnt_clr_r;
    reg xtal_warm_r;
    wire cnt_done;
    wire sw_en;
    wire [2:0] fallback_sel;
    wire need_pll;
    wire need_xtal;
    wire low_power_rc_osc_keep;
    reg [4:0] osc_need_nxt;

    assign sw_en = !switch_enable_config_n;
    assign fallback_sel = (active_clock_select == `CSPSC_SEL_PRIPLL ||
        active_clock_select == `CSPSC_SEL_FAST_RC_MULTIPLIED) ?
        `CSPSC_SEL_FAST_RC_MULTIPLIED : `CSPSC_SEL_FRC;
    assign need_pll = (requested_clock_select == `CSPSC_SEL_PRIPLL) ||
        (requested_clock_select == `CSPSC_SEL_FAST_RC_MULTIPLIED);
    assign need_xtal = (requested_clock_select == `CSPSC_SEL_PRI) ||
        (requested_clock_select == `CSPSC_SEL_PRIPLL);
    // Monitor keeps the low-power RC outside sleep; watchdog keeps it always
    assign low_power_rc_osc_keep = wdt_enabled || (sw_en && ps_state_r != `CSPSC_PS_SLEEP);

    cspsc_edge_count #(
        .CW(4)
    ) u_cnt (
        .clk(clk),
        .rst(rst),
        .clr(cnt_clr_r),
        .src_clk_lvl(new_clk_lvl),
        .target(`CSPSC_SETTLE_CYCLES),
        .done(cnt_done)
    );

    function [4:0] osc_for;
        input [2:0] sel;
        begin
            osc_for = 5'h00;
            case (sel)
                `CSPSC_SEL_FRC, `CSPSC_SEL_FRC16, `CSPSC_SEL_FRCN: begin
                    osc_for[`CSPSC_OSC_FRC] = 1'b1;
                end
                `CSPSC_SEL_FAST_RC_MULTIPLIED: begin
                    osc_for[`CSPSC_OSC_FRC] = 1'b1;
                    osc_for[`CSPSC_OSC_PLL] = 1'b1;
                end
                `CSPSC_SEL_PRI: begin
                    osc_for[`CSPSC_OSC_PRI] = 1'b1;
                end
                `CSPSC_SEL_PRIPLL: begin
                    osc_for[`CSPSC_OSC_PRI] = 1'b1;
                    osc_for[`CSPSC_OSC_PLL] = 1'b1;
                end
                `CSPSC_SEL_SEC: begin
                    osc_for[`CSPSC_OSC_SEC] = 1'b1;
                end
                default: begin
                    osc_for[`CSPSC_OSC_LOW_POWER_RC_OSC] = 1'b1;
                end
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator enables; old source drops once active select moves on
    always @* begin
        osc_need_nxt = osc_for(active_clock_select);
        if (sw_state_r != `CSPSC_ST_IDLE) begin
            osc_need_nxt = osc_need_nxt | osc_for(requested_clock_select);
        end
        if (ps_state_r == `CSPSC_PS_SLEEP) begin
            osc_need_nxt = 5'h00;
        end
        if (low_power_rc_osc_keep) begin
            osc_need_nxt[`CSPSC_OSC_LOW_POWER_RC_OSC] = 1'b1;
        end
        if (secondary_osc_enable) begin
            osc_need_nxt[`CSPSC_OSC_SEC] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch sequencer and control/status bits
    always @(posedge clk) begin
        if (rst) begin
            cfg_taken_r <= 1'b0;
            requested_clock_select <= `CSPSC_SEL_FRCN;
            active_clock_select <= `CSPSC_SEL_FRCN;
            switch_request_flag <= 1'b0;
            clock_fail_flag <= 1'b0;
            lock_status <= 1'b0;
            clock_fail_trap <= 1'b0;
            sw_state_r <= `CSPSC_ST_IDLE;
            cnt_clr_r <= 1'b1;
            xtal_warm_r <= 1'b0;
            osc_enable <= 5'h00;
        end else begin
            clock_fail_trap <= 1'b0;
            cnt_clr_r <= 1'b1;
            osc_enable <= osc_need_nxt;
            lock_status <= pll_locked && (sw_state_r != `CSPSC_ST_START || !need_pll);
            // Strap sampled after reset release, not under reset
            if (!cfg_taken_r) begin
                cfg_taken_r <= 1'b1;
                active_clock_select <= reset_clock_source_config;
                requested_clock_select <= reset_clock_source_config;
            end else if (!sw_en) begin
                active_clock_select <= reset_clock_source_config;
                switch_request_flag <= 1'b0;
                sw_state_r <= `CSPSC_ST_IDLE;
            end else begin
                // Software writes to select are assumed to follow unlock
                if (sel_wr && sw_state_r == `CSPSC_ST_IDLE) begin
                    requested_clock_select <= sel_wr_data;
                end
                if (clock_fail_flag_clr) begin
                    clock_fail_flag <= 1'b0;
                end
                if (osc_fail && ps_state_r != `CSPSC_PS_SLEEP) begin
                    // Fallback overrides any switch in flight
                    clock_fail_flag <= 1'b1;
                    clock_fail_trap <= 1'b1;
                    active_clock_select <= fallback_sel;
                    requested_clock_select <= fallback_sel;
                    switch_request_flag <= 1'b0;
                    sw_state_r <= `CSPSC_ST_IDLE;
                end else begin
                    case (sw_state_r)
                        `CSPSC_ST_IDLE: begin
                            if (req_wr && req_wr_data) begin
                                switch_request_flag <= 1'b1;
                                sw_state_r <= `CSPSC_ST_DONE;
                            end
                            if (switch_request_flag) begin
                                if (requested_clock_select == active_clock_select) begin
                                    switch_request_flag <= 1'b0;
                                    sw_state_r <= `CSPSC_ST_IDLE;
                                end else begin
                                    lock_status <= 1'b0;
                                    // A crystal already running needs no startup wait
                                    xtal_warm_r <= osc_running[`CSPSC_OSC_PRI];
                                    if (!(clock_fail_flag_clr == 1'b0 && osc_fail)) begin
                                        clock_fail_flag <= 1'b0;
                                    end
                                    sw_state_r <= `CSPSC_ST_START;
                                end
                            end
                        end
                        `CSPSC_ST_START: begin
                            if ((!need_xtal || xtal_warm_r || crystal_startup_done) &&
                                (!need_pll || pll_locked)) begin
                                cnt_clr_r <= 1'b0;
                                sw_state_r <= `CSPSC_ST_COUNT;
                            end
                        end
                        `CSPSC_ST_COUNT: begin
                            cnt_clr_r <= 1'b0;
                            if (cnt_done) begin
                                active_clock_select <= requested_clock_select;
                                switch_request_flag <= 1'b0;
                                sw_state_r <= `CSPSC_ST_IDLE;
                            end
                        end
                        `CSPSC_ST_DONE: begin
                            sw_state_r <= `CSPSC_ST_IDLE;
                        end
                        default: begin
                            sw_state_r <= `CSPSC_ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep and idle; the active select is untouched so wake resumes on it
    always @(posedge clk) begin
        if (rst) begin
            ps_state_r <= `CSPSC_PS_RUN;
            wake_pend_r <= 1'b0;
            wdt_clear <= 1'b0;
            sys_clk_gate_en <= 1'b1;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            in_sleep <= 1'b0;
            in_idle <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            wdt_clear <= 1'b0;
            wake_pulse <= 1'b0;
            case (ps_state_r)
                `CSPSC_PS_RUN: begin
                    if (ps_exec) begin
                        // Interrupt during entry is held, not dropped
                        wake_pend_r <= irq_wake;
                        wdt_clear <= 1'b1;
                        cpu_clk_en <= 1'b0;
                        if (ps_sleep_sel) begin
                            ps_state_r <= `CSPSC_PS_SLEEP;
                            sys_clk_gate_en <= 1'b0;
                            periph_clk_en <= 1'b0;
                            in_sleep <= 1'b1;
                        end else begin
                            ps_state_r <= `CSPSC_PS_IDLE;
                            in_idle <= 1'b1;
                        end
                    end
                end
                `CSPSC_PS_SLEEP, `CSPSC_PS_IDLE: begin
                    if (irq_wake || wdt_timeout || wake_pend_r) begin
                        ps_state_r <= `CSPSC_PS_RUN;
                        wake_pend_r <= 1'b0;
                        sys_clk_gate_en <= 1'b1;
                        cpu_clk_en <= 1'b1;
                        periph_clk_en <= 1'b1;
                        in_sleep <= 1'b0;
                        in_idle <= 1'b0;
                        wake_pulse <= 1'b1;
                    end
                end
                default: begin
                    ps_state_r <= `CSPSC_PS_RUN;
                end
            endcase
        end
    end
endmodule

// ---- cspsc_osc_model.sv ----
// Behavioural oscillators beside the controller: source clock, startup and lock
`timescale 1ns/100ps
module cspsc_osc_model (
    input wire clk,
    input wire rst,
    input wire [4:0] osc_enable,
    output reg new_clk_lvl,
    output wire crystal_startup_done,
    output wire pll_locked,
    output reg [4:0] osc_running
);
    reg [4:0] xtal_r;
    reg [2:0] pll_r;
    // Slow crystal and quick lock, so both kinds of wait get exercised
    assign crystal_startup_done = xtal_r == 5'h14;
    assign pll_locked = pll_r == 3'h6;
    always @(posedge clk) begin
        if (rst) begin
            new_clk_lvl <= 1'b0;
            xtal_r <= 5'h00;
            pll_r <= 3'h0;
            osc_running <= 5'h00;
        end else begin
            // Running status trails the enable by one cycle
            osc_running <= osc_enable;
            // Source clock stands still while every oscillator is off
            new_clk_lvl <= (|osc_enable) ? ~new_clk_lvl : new_clk_lvl;
            xtal_r <= !osc_enable[1] ? 5'h00 : xtal_r + {4'h0, xtal_r != 5'h14};
            pll_r <= !osc_enable[4] ? 3'h0 : pll_r + {2'h0, pll_r != 3'h6};
        end
    end
endmodule

// ---- cspsc_sva.sv ----
// Port assertions for the clock switch and power save controller
`timescale 1ns/100ps
module cspsc_sva (
    input wire clk, rst, switch_enable_config_n, osc_fail, ps_exec, irq_wake,
    input wire new_clk_lvl, switch_request_flag, clock_fail_flag, lock_status,
    input wire clock_fail_trap, wdt_clear, sys_clk_gate_en, cpu_clk_en,
    input wire periph_clk_en, in_sleep, in_idle, wake_pulse,
    input wire [2:0] reset_clock_source_config, requested_clock_select,
    input wire [2:0] active_clock_select,
    input wire [4:0] osc_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reg [4:0] edges_r;
    reg lvl_r;
    // Counts source edges from the request on; saturates so it cannot wrap
    always @(posedge clk) begin
        lvl_r <= new_clk_lvl;
        if (rst || !switch_request_flag)
            edges_r <= 5'h00;
        else if (new_clk_lvl && !lvl_r && edges_r != 5'h1F)
            edges_r <= edges_r + 5'h01;
    end
    a_off_flag_low: assert property (switch_enable_config_n && $past(switch_enable_config_n)
        |-> !switch_request_flag) else $error("flag set while off");
    a_off_active_cfg: assert property (switch_enable_config_n && $past(switch_enable_config_n)
        |=> active_clock_select == $past(reset_clock_source_config)) else $error("bad select");
    a_equal_abort: assert property ($rose(switch_request_flag)
        && requested_clock_select == active_clock_select |-> ##[1:3] !switch_request_flag)
        else $error("no abort");
    a_start_clears: assert property ($rose(switch_request_flag)
        && requested_clock_select != active_clock_select
        |-> ##[1:4] (!lock_status && !clock_fail_flag)) else $error("flags kept");
    a_done_copies: assert property ($fell(switch_request_flag)
        |-> active_clock_select == requested_clock_select) else $error("no copy");
    a_settle_count: assert property ($fell(switch_request_flag)
        && active_clock_select != $past(active_clock_select) |-> edges_r >= 5'h0A)
        else $error("changed too early");
    a_fail_trap: assert property (osc_fail && !switch_enable_config_n && !in_sleep
        && !switch_request_flag |=> clock_fail_flag && clock_fail_trap) else $error("no trap");
    a_fail_fallback: assert property (osc_fail && !switch_enable_config_n && !in_sleep
        && !switch_request_flag |=> active_clock_select
        == ((($past(active_clock_select) & 3'h5) == 3'h1) ? 3'h1 : 3'h0)) else $error("fallback");
    a_sleep_gates: assert property (in_sleep |-> !sys_clk_gate_en
        && !periph_clk_en && !cpu_clk_en) else $error("clock on in sleep");
    a_entry_wdt_clr: assert property ($rose(in_sleep) || $rose(in_idle)
        |-> wdt_clear) else $error("no watchdog clear");
    a_idle_wake: assert property (in_idle && irq_wake |=> cpu_clk_en
        && wake_pulse && !in_idle) else $error("slow idle wake");
    a_held_irq: assert property (ps_exec && irq_wake && !in_sleep && !in_idle
        |=> (in_sleep || in_idle) ##1 wake_pulse) else $error("irq not held");
endmodule
bind cspsc_top cspsc_sva u_sva (.clk, .rst, .switch_enable_config_n, .osc_fail, .ps_exec,
    .irq_wake, .new_clk_lvl, .switch_request_flag, .clock_fail_flag, .lock_status,
    .clock_fail_trap, .wdt_clear, .sys_clk_gate_en, .cpu_clk_en, .periph_clk_en, .in_sleep,
    .in_idle, .wake_pulse, .reset_clock_source_config, .requested_clock_select,
    .active_clock_select, .osc_enable);

// ---- tb_top.sv ----
// Self-checking bench for the clock switch and power save controller
`timescale 1ns/100ps
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg switch_enable_config_n = 1'b0, wdt_enabled = 1'b0, sel_wr = 1'b0, req_wr = 1'b0;
    reg req_wr_data = 1'b1, secondary_osc_enable = 1'b0, clock_fail_flag_clr = 1'b0;
    reg osc_fail = 1'b0, ps_exec = 1'b0, ps_sleep_sel = 1'b0, irq_wake = 1'b0;
    reg wdt_timeout = 1'b0;
    reg [2:0] reset_clock_source_config = 3'h0, sel_wr_data = 3'h0;
    wire crystal_startup_done, pll_locked, new_clk_lvl, switch_request_flag, clock_fail_flag;
    wire lock_status, clock_fail_trap, wdt_clear, sys_clk_gate_en, cpu_clk_en, periph_clk_en;
    wire in_sleep, in_idle, wake_pulse;
    wire [2:0] requested_clock_select, active_clock_select;
    wire [4:0] osc_enable, osc_running;
    integer miscompares = 0, total_checks = 0, cycles = 0, i;
    // Rows of {requested, expected active}; never a direct 1<->3 step
    logic [5:0] rows [10] = '{6'h12, 6'h1B, 6'h00, 6'h09, 6'h24, 6'h2D, 6'h36, 6'h3F,
        6'h3F, 6'h00};
    cspsc_top uut (.clk, .rst, .switch_enable_config_n, .reset_clock_source_config,
        .wdt_enabled, .sel_wr, .sel_wr_data, .req_wr, .req_wr_data, .secondary_osc_enable,
        .clock_fail_flag_clr, .osc_running, .crystal_startup_done, .pll_locked,
        .new_clk_lvl, .osc_fail, .ps_exec, .ps_sleep_sel, .irq_wake, .wdt_timeout,
        .requested_clock_select, .active_clock_select, .switch_request_flag,
        .clock_fail_flag, .lock_status, .osc_enable, .clock_fail_trap, .wdt_clear,
        .sys_clk_gate_en, .cpu_clk_en, .periph_clk_en, .in_sleep, .in_idle, .wake_pulse);
    cspsc_osc_model osc (.clk, .rst, .osc_enable, .new_clk_lvl, .crystal_startup_done,
        .pll_locked, .osc_running);
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    // Inputs move 1 ns after the edge, well clear of sampling
    task step(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task chk(input [4:0] got, input [4:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task do_switch(input [2:0] s);
        integer n;
        begin
            sel_wr_data = s;
            sel_wr = 1'b1;
            step(1);
            sel_wr = 1'b0;
            step(1);
            req_wr = 1'b1;
            step(1);
            req_wr = 1'b0;
            n = 0;
            step(1);
            while (switch_request_flag !== 1'b0 && n < 300) begin
                step(1);
                n = n + 1;
            end
            chk(n >= 300, 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        step(6);
        rst = 1'b0;
        step(2);
        for (i = 0; i < 10; i = i + 1) begin
            do_switch(rows[i][5:3]);
            chk(active_clock_select, rows[i][2:0]);
            chk(requested_clock_select, rows[i][2:0]);
            if (i == 0) begin
                step(2);
                chk(osc_enable, 5'h0A);
            end
            if (i == 5) begin
                step(2);
                chk(osc_enable, 5'h08);
                secondary_osc_enable = 1'b1;
                step(2);
                chk(osc_enable, 5'h0C);
                secondary_osc_enable = 1'b0;
            end
        end
        $display("test switch rows done");
        do_switch(3'h3);
        osc_fail = 1'b1;
        step(1);
        osc_fail = 1'b0;
        chk(clock_fail_trap, 1'b1);
        chk(clock_fail_flag, 1'b1);
        chk(active_clock_select, 3'h1);
        do_switch(3'h2);
        chk(clock_fail_flag, 1'b0);
        osc_fail = 1'b1;
        step(1);
        osc_fail = 1'b0;
        clock_fail_flag_clr = 1'b1;
        chk(active_clock_select, 3'h0);
        step(1);
        clock_fail_flag_clr = 1'b0;
        chk(clock_fail_flag, 1'b0);
        step(1);
        osc_fail = 1'b1;
        clock_fail_flag_clr = 1'b1;
        step(1);
        osc_fail = 1'b0;
        clock_fail_flag_clr = 1'b0;
        chk(clock_fail_flag, 1'b1);
        $display("test fail fallback done");
        wdt_enabled = 1'b1;
        ps_sleep_sel = 1'b1;
        ps_exec = 1'b1;
        step(1);
        ps_exec = 1'b0;
        chk(in_sleep, 1'b1);
        chk(wdt_clear, 1'b1);
        chk(sys_clk_gate_en, 1'b0);
        step(3);
        chk(osc_enable, 5'h08);
        irq_wake = 1'b1;
        step(1);
        irq_wake = 1'b0;
        chk(wake_pulse, 1'b1);
        chk(active_clock_select, 3'h0);
        $display("test sleep done");
        ps_sleep_sel = 1'b0;
        ps_exec = 1'b1;
        irq_wake = 1'b1;
        step(1);
        ps_exec = 1'b0;
        irq_wake = 1'b0;
        chk(in_idle, 1'b1);
        chk(sys_clk_gate_en, 1'b1);
        chk(cpu_clk_en, 1'b0);
        step(1);
        chk(cpu_clk_en, 1'b1);
        ps_exec = 1'b1;
        step(1);
        ps_exec = 1'b0;
        step(2);
        wdt_timeout = 1'b1;
        step(1);
        wdt_timeout = 1'b0;
        chk(in_idle, 1'b0);
        ps_exec = 1'b1;
        step(1);
        ps_exec = 1'b0;
        step(1);
        irq_wake = 1'b1;
        step(1);
        irq_wake = 1'b0;
        chk(cpu_clk_en, 1'b1);
        chk(wake_pulse, 1'b1);
        $display("test idle done");
        rst = 1'b1;
        switch_enable_config_n = 1'b1;
        reset_clock_source_config = 3'h5;
        step(6);
        rst = 1'b0;
        step(2);
        do_switch(3'h2);
        osc_fail = 1'b1;
        step(1);
        osc_fail = 1'b0;
        chk(switch_request_flag, 1'b0);
        chk(active_clock_select, 3'h5);
        chk(clock_fail_flag, 1'b0);
        $display("test switching off done");
        give_verdict;
    end
endmodule
